// >>> verilog/framer_pkg.sv
/*
 * Constants for the satellite position section and clock-reference
 * insertion packet framer. Assumes byte-wide transport stream output.
 */
// Functional notes
// - section: 64-bit header, 8-bit count, count+1 entries
// - entry: 8-bit id, x/y/z 32-bit floats MSB first
// - section ends with CRC-32 leaving decoder zero
// - reserved bits sit between PCR base and extension, driven one
// - section packets use program-map assigned packet identifier
// - position table may be disabled entirely
// - payload present: start indicator 1, pointer first
// - pointer zero: section directly follows pointer
// - adaptation control 10 without payload, 11 with
// - payload bytes only when adaptation control 11
// - adaptation length 7, only PCR flag set
// - PCR base/extension from inserted clock count
// - error, priority, discontinuity, random access bits zero
// - position section may run on into following packets; clock payload clipped to one packet
package framer_pkg;
  localparam logic [7:0] SYNC_BYTE = 8'h47;
  localparam int unsigned PKT_LEN = 188;
  localparam int unsigned HDR_LEN = 4;
  localparam logic [7:0] AF_LEN = 8'h07;
  localparam logic [7:0] AF_FLAGS = 8'h10;
  localparam logic [1:0] AFC_ONLY = 2'h2;
  localparam logic [1:0] AFC_PAYLOAD = 2'h3;
  localparam logic [7:0] POINTER_VAL = 8'h00;
  localparam logic [7:0] STUFF_BYTE = 8'hFF;
  localparam int unsigned PCR_BYTES = 6;
  localparam int unsigned AF_TOTAL = 8;
  localparam int unsigned PAY_MAX = PKT_LEN - HDR_LEN - AF_TOTAL - 1;
  localparam int unsigned SECT_HDR_BYTES = 8;
  localparam int unsigned ENTRY_BYTES = 13;
  localparam int unsigned CRC_BYTES = 4;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam int unsigned PCR_EXT_MOD = 300;
  typedef enum logic [1:0] {PK_IDLE, PK_CLKREF, PK_SECT} pkt_kind_t;
endpackage

// >>> verilog/crc32_step.sv
/*
 * Byte-wide section CRC-32 update, MSB first, no reflection.
 * Assumes caller holds the running register.
 */
`timescale 1ns/1ps
module crc32_step
  import framer_pkg::*;
(
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);
  always_comb
  begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[31] ^ data[i])
        c = {c[30:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[30:0], 1'b0};
    end
    crc_out = c;
  end
endmodule // crc32_step

// >>> verilog/sat_position_clock_ref_framer.sv
/*
 * Builds satellite position sections and clock-reference insertion
 * packets as 188-byte transport stream packets on a byte stream.
 * Assumes the section header bytes and entries come from a same-clock
 * source; the sink may stall with TS_READY.
 */
`timescale 1ns/1ps
module sat_position_clock_ref_framer
  import framer_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic POS_ENABLE,
  input wire logic [12:0] POS_PID,
  input wire logic [12:0] CLKREF_PID,
  input wire logic [1:0] SCRAMBLE_CTRL,
  input wire logic CLKREF_START,
  input wire logic [41:0] CLKREF_COUNT,
  input wire logic CLKREF_HAS_PAYLOAD,
  input wire logic [7:0] CLKREF_PAY_LEN,
  input wire logic [7:0] CLKREF_PAY_DATA,
  output logic CLKREF_PAY_TAKE,
  input wire logic POS_START,
  input wire logic [63:0] POS_HEADER,
  input wire logic [7:0] POS_LOOP_COUNT,
  input wire logic [7:0] SAT_ID,
  input wire logic [31:0] SAT_X,
  input wire logic [31:0] SAT_Y,
  input wire logic [31:0] SAT_Z,
  output logic SAT_TAKE,
  output logic BUSY,
  output logic [7:0] TS_DATA,
  output logic TS_VALID,
  output logic TS_SOP,
  input wire logic TS_READY
);
  typedef enum {ST_IDLE, ST_HDR, ST_AF, ST_PTR, ST_PAY, ST_SHDR, ST_CNT,
    ST_ENT, ST_CRC, ST_STUFF} state_t;
  state_t st_q;
  pkt_kind_t kind_q;
  logic [7:0] pos_q;
  logic [3:0] sub_q;
  state_t resume_q;
  logic [3:0] sub_save_q;
  logic [7:0] left_q;
  logic [7:0] ent_left_q;
  logic cont_q;
  logic [31:0] crc_q;
  logic [31:0] crc_nx;
  logic [41:0] clk_ref_q;
  logic pay_q;
  logic [7:0] pay_len_q;
  logic [63:0] shdr_q;
  logic [103:0] ent_q;
  logic [7:0] byte_d;
  logic [7:0] data_q;
  logic valid_q;
  logic sop_q;
  logic adv;
  logic [32:0] pcr_base;
  logic [8:0] pcr_ext;
  logic [12:0] pid_sel;
  logic sect_byte;

  assign adv = !valid_q || TS_READY;
  assign pcr_base = clk_ref_q[41:9];
  assign pcr_ext = clk_ref_q[8:0];
  assign pid_sel = (kind_q == PK_CLKREF) ? CLKREF_PID : POS_PID;
  assign sect_byte = (st_q == ST_SHDR) || (st_q == ST_CNT) || (st_q == ST_ENT);
  assign TS_DATA = data_q;
  assign TS_VALID = valid_q;
  assign TS_SOP = sop_q;
  assign BUSY = st_q != ST_IDLE;
  assign CLKREF_PAY_TAKE = adv && st_q == ST_PAY;
  // first entry on the count byte, later ones on the last byte of the previous
  assign SAT_TAKE = adv && (st_q == ST_CNT || (st_q == ST_ENT &&
    sub_q == 4'(ENTRY_BYTES - 1) && ent_left_q != 8'h00));

  crc32_step u_crc (
    .crc_in(crc_q),
    .data(byte_d),
    .crc_out(crc_nx)
  );

  // byte selection for the current position
  always_comb
  begin
    byte_d = STUFF_BYTE;
    case (st_q)
      ST_HDR:
        case (sub_q)
          4'h0: byte_d = SYNC_BYTE;
          4'h1: byte_d = {1'b0, (kind_q == PK_SECT) ? ~cont_q : pay_q, 1'b0,
            pid_sel[12:8]};
          4'h2: byte_d = pid_sel[7:0];
          default: byte_d = {SCRAMBLE_CTRL,
            (kind_q == PK_CLKREF && !pay_q) ? AFC_ONLY : 2'h1, 4'h0};
        endcase
      ST_AF:
        case (sub_q)
          4'h0: byte_d = AF_LEN;
          4'h1: byte_d = AF_FLAGS;
          4'h2: byte_d = pcr_base[32:25];
          4'h3: byte_d = pcr_base[24:17];
          4'h4: byte_d = pcr_base[16:9];
          4'h5: byte_d = pcr_base[8:1];
          4'h6: byte_d = {pcr_base[0], 6'h3F, pcr_ext[8]};
          default: byte_d = pcr_ext[7:0];
        endcase
      ST_PTR: byte_d = POINTER_VAL;
      ST_PAY: byte_d = CLKREF_PAY_DATA;
      ST_SHDR: byte_d = shdr_q[63:56];
      ST_CNT: byte_d = left_q;
      ST_ENT: byte_d = ent_q[103:96];
      ST_CRC: byte_d = crc_q[31:24];
      default: byte_d = STUFF_BYTE;
    endcase
  end

  // clock packet header needs AFC 11 when payload present
  logic [7:0] out_d;
  always_comb
  begin
    out_d = byte_d;
    if (st_q == ST_HDR && sub_q == 4'h3 && kind_q == PK_CLKREF && pay_q)
      out_d = {SCRAMBLE_CTRL, AFC_PAYLOAD, 4'h0};
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      data_q <= 8'h00;
      valid_q <= 1'b0;
      sop_q <= 1'b0;
    end
    else if (adv)
    begin
      valid_q <= st_q != ST_IDLE;
      data_q <= out_d;
      sop_q <= st_q == ST_HDR && sub_q == 4'h0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      crc_q <= CRC_INIT;
    else if (st_q == ST_IDLE)
      crc_q <= CRC_INIT;
    else if (adv && sect_byte)
      crc_q <= crc_nx;
    else if (adv && st_q == ST_CRC)
      crc_q <= {crc_q[23:0], 8'h00};
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      st_q <= ST_IDLE;
      kind_q <= PK_IDLE;
      pos_q <= 8'h00;
      sub_q <= 4'h0;
      left_q <= 8'h00;
      ent_left_q <= 8'h00;
      cont_q <= 1'b0;
      clk_ref_q <= '0;
      resume_q <= ST_IDLE;
      sub_save_q <= 4'h0;
      pay_q <= 1'b0;
      pay_len_q <= 8'h00;
      shdr_q <= '0;
      ent_q <= '0;
    end
    else if (adv)
    begin
      if (st_q != ST_IDLE)
        pos_q <= pos_q + 8'h01;
      case (st_q)
        ST_IDLE:
        begin
          pos_q <= 8'h00;
          sub_q <= 4'h0;
          cont_q <= 1'b0;
          kind_q <= PK_IDLE;
          if (CLKREF_START)
          begin
            kind_q <= PK_CLKREF;
            clk_ref_q <= CLKREF_COUNT;
            // payload clipped to what one packet holds
            pay_q <= CLKREF_HAS_PAYLOAD && CLKREF_PAY_LEN != 8'h00;
            pay_len_q <= (CLKREF_PAY_LEN > 8'(PAY_MAX)) ? 8'(PAY_MAX) : CLKREF_PAY_LEN;
            st_q <= ST_HDR;
          end
          else if (POS_START && POS_ENABLE)
          begin
            kind_q <= PK_SECT;
            shdr_q <= POS_HEADER;
            left_q <= POS_LOOP_COUNT;
            ent_left_q <= POS_LOOP_COUNT;
            sub_q <= 4'h0;
            st_q <= ST_HDR;
          end
        end
        ST_HDR:
        begin
          sub_q <= sub_q + 4'h1;
          if (sub_q == 4'h3)
          begin
            sub_q <= 4'h0;
            if (kind_q == PK_CLKREF)
              st_q <= ST_AF;
            else if (cont_q)
            begin
              st_q <= resume_q;
              sub_q <= sub_save_q;
            end
            else
              st_q <= ST_PTR;
          end
        end
        ST_AF:
        begin
          sub_q <= sub_q + 4'h1;
          if (sub_q == 4'h7)
          begin
            sub_q <= 4'h0;
            st_q <= pay_q ? ST_PTR : ST_STUFF;
          end
        end
        ST_PTR:
          st_q <= (kind_q == PK_CLKREF) ? ST_PAY : ST_SHDR;
        ST_PAY:
        begin
          pay_len_q <= pay_len_q - 8'h01;
          if (pay_len_q == 8'h01)
            st_q <= (pos_q == 8'(PKT_LEN - 1)) ? ST_IDLE : ST_STUFF;
        end
        ST_SHDR:
        begin
          shdr_q <= {shdr_q[55:0], 8'h00};
          sub_q <= sub_q + 4'h1;
          if (sub_q == 4'h7)
          begin
            sub_q <= 4'h0;
            st_q <= ST_CNT;
          end
        end
        ST_CNT:
        begin
          ent_q <= {SAT_ID, SAT_X, SAT_Y, SAT_Z};
          sub_q <= 4'h0;
          st_q <= ST_ENT;
        end
        ST_ENT:
        begin
          ent_q <= {ent_q[95:0], 8'h00};
          sub_q <= sub_q + 4'h1;
          sub_save_q <= sub_q + 4'h1;
          resume_q <= ST_ENT;
          if (sub_q == 4'(ENTRY_BYTES - 1))
          begin
            sub_q <= 4'h0;
            sub_save_q <= 4'h0;
            if (ent_left_q == 8'h00)
            begin
              st_q <= ST_CRC;
              resume_q <= ST_CRC;
            end
            else
            begin
              ent_left_q <= ent_left_q - 8'h01;
              ent_q <= {SAT_ID, SAT_X, SAT_Y, SAT_Z};
            end
          end
          // packet full: header of the next packet, then resume
          if (pos_q == 8'(PKT_LEN - 1))
          begin
            cont_q <= 1'b1;
            pos_q <= 8'h00;
            sub_q <= 4'h0;
            st_q <= ST_HDR;
          end
        end
        ST_CRC:
        begin
          sub_q <= sub_q + 4'h1;
          if (sub_q == 4'h3)
          begin
            st_q <= (pos_q == 8'(PKT_LEN - 1)) ? ST_IDLE : ST_STUFF;
            if (pos_q == 8'(PKT_LEN - 1))
              kind_q <= PK_IDLE;
          end
          else if (pos_q == 8'(PKT_LEN - 1))
          begin
            cont_q <= 1'b1;
            pos_q <= 8'h00;
            sub_q <= 4'h0;
            sub_save_q <= sub_q + 4'h1;
            resume_q <= ST_CRC;
            st_q <= ST_HDR;
          end
        end
        ST_STUFF:
          if (pos_q == 8'(PKT_LEN - 1))
          begin
            st_q <= ST_IDLE;
            kind_q <= PK_IDLE;
          end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  AST_SOP_SYNC: assert property (@(posedge CLK) disable iff (!RSTN)
    TS_VALID && TS_SOP |-> TS_DATA == SYNC_BYTE) else $error("sop without sync");
  AST_AF_LEN: assert property (@(posedge CLK) disable iff (!RSTN)
    st_q == ST_AF && sub_q == 4'h0 && adv |=> TS_DATA == AF_LEN)
    else $error("bad adaptation length");
  AST_AF_FLAGS: assert property (@(posedge CLK) disable iff (!RSTN)
    st_q == ST_AF && sub_q == 4'h1 && adv |=> TS_DATA == AF_FLAGS)
    else $error("bad adaptation flags");
  AST_AFC: assert property (@(posedge CLK) disable iff (!RSTN)
    st_q == ST_HDR && sub_q == 4'h3 && kind_q == PK_CLKREF && adv
    |=> TS_DATA[5:4] == (pay_q ? AFC_PAYLOAD : AFC_ONLY)) else $error("bad afc");
  AST_PUSI: assert property (@(posedge CLK) disable iff (!RSTN)
    st_q == ST_HDR && sub_q == 4'h1 && kind_q == PK_CLKREF && adv
    |=> TS_DATA[6] == pay_q && TS_DATA[7] == 1'b0 && TS_DATA[5] == 1'b0)
    else $error("bad header flags");
  AST_PTR: assert property (@(posedge CLK) disable iff (!RSTN)
    st_q == ST_PTR && adv |=> TS_DATA == POINTER_VAL) else $error("bad pointer");
  AST_NO_PAY: assert property (@(posedge CLK) disable iff (!RSTN)
    kind_q == PK_CLKREF && !pay_q |-> st_q != ST_PAY) else $error("payload without afc 11");
  AST_POS_OFF: assert property (@(posedge CLK) disable iff (!RSTN)
    st_q == ST_IDLE && !POS_ENABLE && !CLKREF_START |=> kind_q != PK_SECT)
    else $error("section sent while disabled");
  AST_PCR_LOAD: assert property (@(posedge CLK) disable iff (!RSTN)
    st_q == ST_IDLE && adv && CLKREF_START |=> clk_ref_q == $past(CLKREF_COUNT))
    else $error("clock value not captured");
endmodule // sat_position_clock_ref_framer

// >>> dv/ts_sink.sv
/*
 Far-side transport stream sink: drives the ready line, optionally stalling.
 Assumes the bench seeds $urandom once before traffic starts.
*/
`timescale 1ns/1ps
module ts_sink (
  input wire logic clk,
  input wire logic stall_en,
  output logic ready
);
  initial ready = 1'b1;
  // random back-pressure when stalling is on
  always @(negedge clk)
    ready <= !stall_en || ($urandom % 3 != 0);
endmodule // ts_sink

// >>> dv/testbench.sv
/*
 Self-checking bench for the framer: clock-reference packets and position
 sections checked byte by byte from a queue. Assumes the ts_sink model.
*/
`timescale 1ns/1ps
module testbench;
  import framer_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pos_en = 1'b1;
  logic clkref_start = 1'b0;
  logic pos_start = 1'b0;
  logic has_pay = 1'b0;
  logic stall = 1'b0;
  logic took = 1'b0;
  logic [12:0] pos_pid = 13'h0;
  logic [12:0] clkref_pid = 13'h0;
  logic [1:0] scr = 2'h0;
  logic [41:0] clkref_count = 42'h0;
  logic [7:0] pay_len = 8'h0;
  logic [7:0] loop_cnt = 8'h0;
  logic [63:0] pos_hdr = 64'h0;
  logic [16:0] head;
  logic [7:0] pd [0:255];
  logic [103:0] ent [0:15];
  logic [7:0] ts_data;
  logic pay_take, sat_take, busy, ts_valid, ts_sop, ts_ready;
  logic [16:0] expq [$];
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  int idx = 0;
  wire [103:0] cur = ent[idx[3:0]];

  ts_sink u_ts_sink (.clk(clk), .stall_en(stall), .ready(ts_ready));
  sat_position_clock_ref_framer u_sat_position_clock_ref_framer (
    .CLK(clk), .RSTN(rstn), .POS_ENABLE(pos_en), .POS_PID(pos_pid), .CLKREF_PID(clkref_pid),
    .SCRAMBLE_CTRL(scr), .CLKREF_START(clkref_start), .CLKREF_COUNT(clkref_count),
    .CLKREF_HAS_PAYLOAD(has_pay), .CLKREF_PAY_LEN(pay_len), .CLKREF_PAY_DATA(pd[idx[7:0]]),
    .CLKREF_PAY_TAKE(pay_take), .POS_START(pos_start), .POS_HEADER(pos_hdr),
    .POS_LOOP_COUNT(loop_cnt), .SAT_ID(cur[103:96]), .SAT_X(cur[95:64]),
    .SAT_Y(cur[63:32]), .SAT_Z(cur[31:0]), .SAT_TAKE(sat_take), .BUSY(busy),
    .TS_DATA(ts_data), .TS_VALID(ts_valid), .TS_SOP(ts_sop), .TS_READY(ts_ready));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic put(input logic [7:0] b, input logic [7:0] m = 8'hFF, input logic s = 1'b0);
    expq.push_back({m, s, b});
  endtask

  task automatic hdr(input logic pusi, input logic [12:0] pid, input logic [1:0] afc);
    put(SYNC_BYTE, 8'hFF, 1'b1);
    put({1'b0, pusi, 1'b0, pid[12:8]});
    put(pid[7:0]);
    put({scr, afc, 4'h0}, 8'hF0); // continuity nibble left unchecked
  endtask

  task automatic go(input logic is_clkref, input int n);
    int t;
    for (t = n; t < PKT_LEN; t++)
      put(STUFF_BYTE);
    idx = 0;
    @(negedge clk);
    clkref_start = is_clkref;
    pos_start = !is_clkref;
    for (t = 0; t < 20 && busy !== 1'b1; t++)
      @(negedge clk);
    clkref_start = 1'b0;
    pos_start = 1'b0;
    for (t = 0; t < 3000 && (busy !== 1'b0 || expq.size() != 0); t++)
    begin
      pos_start = is_clkref && t >= 30 && t < 33; // refused while busy
      @(negedge clk);
    end
    check(10'(expq.size()), 10'h0);
  endtask

  task automatic send_clkref(input logic pay, input logic [7:0] len);
    logic [32:0] base;
    logic [8:0] ext;
    base = 33'({$urandom, $urandom});
    ext = 9'($urandom % PCR_EXT_MOD);
    clkref_count = {base, ext};
    has_pay = pay;
    pay_len = len;
    scr = 2'($urandom);
    clkref_pid = 13'($urandom);
    for (int i = 0; i < 256; i++)
      pd[i] = 8'($urandom);
    hdr(pay, clkref_pid, pay ? AFC_PAYLOAD : AFC_ONLY);
    put(AF_LEN);
    put(AF_FLAGS);
    for (int k = 0; k < 4; k++)
      put(base[32-8*k -: 8]);
    put({base[0], 6'h00, ext[8]}, 8'h81);
    put(ext[7:0]);
    if (pay)
    begin
      put(POINTER_VAL);
      for (int i = 0; i < len; i++)
        put(pd[i]);
    end
    go(1'b1, HDR_LEN + AF_TOTAL + (pay ? len + 1 : 0));
  endtask

  task automatic send_pos(input logic [7:0] cnt);
    logic [31:0] crc;
    logic [7:0] b [$];
    int n;
    pos_pid = 13'($urandom);
    scr = 2'($urandom);
    loop_cnt = cnt;
    pos_hdr = {$urandom, $urandom};
    for (int i = 0; i < 8; i++)
      b.push_back(pos_hdr[63-8*i -: 8]);
    b.push_back(cnt);
    for (int e = 0; e <= cnt; e++)
    begin
      ent[e] = {8'($urandom), $urandom, $urandom, $urandom};
      for (int k = 0; k < 13; k++)
        b.push_back(ent[e][103-8*k -: 8]);
    end
    crc = CRC_INIT;
    foreach (b[i])
      for (int j = 7; j >= 0; j--)
        crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ b[i][j]) ? CRC_POLY : 32'h0);
    for (int k = 0; k < 4; k++)
      b.push_back(crc[31-8*k -: 8]);
    // receiver view: whole section, CRC included, leaves zero
    crc = CRC_INIT;
    foreach (b[i])
      for (int j = 7; j >= 0; j--)
        crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ b[i][j]) ? CRC_POLY : 32'h0);
    check(10'(crc == 32'h0), 10'h1);
    hdr(1'b1, pos_pid, 2'h1);
    put(POINTER_VAL);
    n = HDR_LEN + 1;
    foreach (b[i])
    begin
      if (n == PKT_LEN)
      begin
        hdr(1'b0, pos_pid, 2'h1);
        n = HDR_LEN;
      end
      put(b[i]);
      n++;
    end
    go(1'b0, n);
  endtask

  // consumed entry or payload byte moves the source on
  always @(posedge clk)
    took <= pay_take === 1'b1 || sat_take === 1'b1;
  always @(negedge clk)
    if (took)
      idx <= idx + 1;

  always @(posedge clk)
    if (rstn && ts_valid === 1'b1 && ts_ready === 1'b1)
    begin
      if (expq.size() == 0)
        check({1'b1, ts_sop, ts_data}, 10'h0);
      else
      begin
        head = expq.pop_front();
        check({1'b0, ts_sop, ts_data & head[16:9]},
              {1'b0, head[8], head[7:0] & head[16:9]});
      end
    end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial
  begin
    void'($urandom(43973));
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    send_clkref(1'b0, 8'h00);
    stall = 1'b1;
    send_clkref(1'b1, 8'h01);
    send_clkref(1'b1, PAY_MAX[7:0]);
    send_pos(8'h00);
    send_pos(8'h02);
    send_pos(8'h0C);
    send_pos(8'h0F);
    pos_en = 1'b0;
    pos_start = 1'b1;
    repeat (5)
    begin
      @(negedge clk);
      check({9'h0, busy}, 10'h0);
    end
    pos_start = 1'b0;
    pos_en = 1'b1;
    repeat (5) @(negedge clk);
    wrap_up();
  end
endmodule // testbench
